//--- src/ais_defines.vh
// register map, field positions and reset values of the interrupt servicer
`ifndef AIS_DEFINES_VH
`define AIS_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define AIS_ADDR_ISR_ALT     8'h04
`define AIS_ADDR_INT_EN      8'h06
`define AIS_ADDR_MOTION_CTRL 8'h09
`define AIS_ADDR_ISR         8'h14
`define AIS_ADDR_FIFO_CTRL   8'h2D
`define AIS_ADDR_FIFO_THR    8'h2E
`define AIS_ADDR_FIFO_ISR    8'h2F
`define AIS_ADDR_SVC_CTRL    8'h31
`define AIS_ADDR_PIN_CTRL    8'h33
`define AIS_ADDR_TL_PERIOD   8'h4A

// ----------------------------------------------------------------
// interrupt status / enable bit positions
// ----------------------------------------------------------------
`define AIS_B_TILT   0
`define AIS_B_FLIP   1
`define AIS_B_GENERIC_MOVEMENT_DETECT   2
`define AIS_B_SHAKE  3
`define AIS_B_DTAP   4
`define AIS_B_FIFOC  5
`define AIS_B_ACQ    7

// fifo control and fifo status
`define AIS_B_FULL   1
`define AIS_B_THR    2
`define AIS_B_COMB   3
`define AIS_B_FIFOEN 5

// motion control feature enables
`define AIS_B_TF_EN    0
`define AIS_B_GENERIC_MOVEMENT_DETECT_EN  2
`define AIS_B_SHAKE_EN 3

// service control
`define AIS_B_MODE_LO  0
`define AIS_B_MODE_HI  1
`define AIS_B_SWAP     4
`define AIS_B_BITMASK  6

// pin control
`define AIS_B_A_POL  2
`define AIS_B_A_DRV  3
`define AIS_B_B_POL  6
`define AIS_B_B_DRV  7

// latch modes
`define AIS_MODE_LATCHED 2'h0
`define AIS_MODE_TEMP    2'h1
`define AIS_MODE_AUTO    2'h2

// ----------------------------------------------------------------
// reset values and fixed figures
// ----------------------------------------------------------------
`define AIS_RST_ZERO     8'h00
`define AIS_RST_FIFO_THR 8'h10
`define AIS_FIFO_DEPTH   6'h20

`endif

//--- src/ais_pin_drv.v
// one interrupt pin driver: polarity and open-drain or push-pull drive
`timescale 1ns/1ps
`default_nettype none

module ais_pin_drv (
	// clock and reset
	input  wire clk_i,
	input  wire arst_n_i,
	input  wire ce_i,
	// request and settings
	input  wire req_i,
	input  wire pol_i,
	input  wire drv_i,
	// pin
	output reg  pin_out_o,
	output reg  pin_oe_o
);

	wire level;

	// pin level is the request seen through the polarity bit
	assign level = pol_i ? req_i : ~req_i;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_out_o <= 1'b0;
			pin_oe_o  <= 1'b0;
		end else if (ce_i) begin
			if (drv_i) begin
				pin_out_o <= level;
				pin_oe_o  <= 1'b1;
			end else begin
				// open drain only ever pulls low
				pin_out_o <= 1'b0;
				pin_oe_o  <= ~level;
			end
		end
	end

endmodule // ais_pin_drv

`default_nettype wire

//--- src/ais_top.v
// interrupt flags, clearing modes and pin routing of the accelerometer
//
// What this block does
// - bitmask clear off: any write to either clear address clears all flags.
// - global clear ignores the written data; only the address matters.
// - bitmask clear on: only the primary status address clears flags.
// - bitmask clear: data ones clear matching flags, zeros leave them.
// - bitmask clear: bit 5 clears both fifo flags together.
// - three latch modes: latched, timer latched, auto clear.
// - fifo flags work only latched and clear only by software.
// - sample flag set at z end; auto mode clears at next z start.
// - double tap not set in timer or auto modes; software clear only.
// - timer mode: sample and motion flags clear on timeout or write.
// - auto mode: motion flags clear on condition end, hw reset, write.
// - latched mode: flags hold until software clears them.
// - shake set on peak and duration; shake and tap need generic_movement_detect enabled.
// - any motion set on lock status and relative threshold.
// - flip on tilt to flip; tilt on flat or flip to tilt.
// - fifo threshold flag set when count reaches programmed threshold.
// - fifo full flag set at 32 samples, in wake with fifo enabled.
// - default: sample plus motion on pin a, fifo on pin b.
// - per pin drive bit: 0 open drain, 1 push pull.
// - per pin polarity bit: 0 active low, 1 active high.
// - swap bit exchanges requests; pin settings stay with the pin.
// - combine bit merges all onto the first request, second disabled.
// - events raise requests only with their enable bit set.
// - sample flag always active and cleared when read.
// - standby: registers answer, flags neither serviced nor cleared.
`timescale 1ns/1ps
`default_nettype none
`include "ais_defines.vh"

module ais_top #(
	parameter integer TL_SHIFT = 8
) (
	// clock, reset, clock enable
	input  wire       clk_i,
	input  wire       arst_n_i,
	input  wire       ce_i,
	// register port
	input  wire [7:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	output reg  [7:0] reg_rdata_o,
	// operating state
	input  wire       wake_i,
	// sample and motion events (same clock domain)
	input  wire       z_done_i,
	input  wire       z_accum_start_i,
	input  wire       dtap_det_i,
	input  wire       shake_det_i,
	input  wire       shake_cond_i,
	input  wire       generic_movement_detect_det_i,
	input  wire       generic_movement_detect_cond_i,
	input  wire       tilt_det_i,
	input  wire       tilt_cond_i,
	input  wire       flip_det_i,
	input  wire       flip_cond_i,
	input  wire       motion_hw_clr_i,
	// fifo state
	input  wire [5:0] fifo_count_i,
	// interrupt pins
	output wire       irq_pin_a_out_o,
	output wire       irq_pin_a_oe_o,
	output wire       irq_pin_b_out_o,
	output wire       irq_pin_b_oe_o
);

	localparam integer TLW = 8 + TL_SHIFT;

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	reg [7:0] int_en;
	reg [7:0] motion_ctrl;
	reg [7:0] fifo_ctrl;
	reg [7:0] fifo_thr;
	reg [7:0] svc_ctrl;
	reg [7:0] irq_pin_drive_polarity;
	reg [7:0] tl_period;

	// flags
	reg [7:0] isr;
	reg [7:0] fifo_isr;
	reg [7:0] next_isr;
	reg [7:0] next_fifo_isr;

	// condition history for auto clear on condition end
	reg [3:0] cond_q;

	// temp latch timer
	reg [TLW-1:0] tl_cnt;
	reg           tl_run;
	reg           tl_expire;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire [1:0] latch_mode;
	wire       bitmask_clear_enable;
	wire       request_pin_exchange;
	wire       request_merge_enable;
	wire       mode_latched;
	wire       mode_temp;
	wire       mode_auto;
	wire       wr_isr;
	wire       wr_isr_alt;
	wire       rd_isr;
	wire       clr_pulse;
	wire [7:0] clr_mask;
	wire       clr_fifo;
	wire [7:0] set_vec;
	wire [7:0] fifo_set_vec;
	wire [3:0] cond_now;
	wire [3:0] cond_end;
	wire       generic_movement_detect_on;
	wire       fifo_en;

	assign latch_mode = svc_ctrl[`AIS_B_MODE_HI:`AIS_B_MODE_LO];
	assign bitmask_clear_enable = svc_ctrl[`AIS_B_BITMASK];
	assign request_pin_exchange = svc_ctrl[`AIS_B_SWAP];
	assign request_merge_enable = fifo_ctrl[`AIS_B_COMB];
	assign mode_latched = (latch_mode == `AIS_MODE_LATCHED);
	assign mode_temp    = (latch_mode == `AIS_MODE_TEMP);
	assign mode_auto    = (latch_mode == `AIS_MODE_AUTO);
	assign generic_movement_detect_on      = motion_ctrl[`AIS_B_GENERIC_MOVEMENT_DETECT_EN];
	assign fifo_en      = fifo_ctrl[`AIS_B_FIFOEN];

	assign wr_isr     = reg_wr_i && (reg_addr_i == `AIS_ADDR_ISR);
	assign wr_isr_alt = reg_wr_i && (reg_addr_i == `AIS_ADDR_ISR_ALT);
	assign rd_isr     = reg_rd_i && ((reg_addr_i == `AIS_ADDR_ISR) ||
	                                 (reg_addr_i == `AIS_ADDR_ISR_ALT));

	// clear pulse lasts the single write cycle; standby blocks it
	assign clr_pulse = wake_i &&
		(bitmask_clear_enable ? wr_isr
		                      : (wr_isr || wr_isr_alt));

	// global clear never looks at the data bus
	assign clr_mask = !clr_pulse ? 8'h00 :
		bitmask_clear_enable ? reg_wdata_i : 8'hFF;
	assign clr_fifo = clr_mask[`AIS_B_FIFOC];

	// ----------------------------------------------------------------
	// set events, each gated by its enable except the sample flag
	// ----------------------------------------------------------------
	assign set_vec[`AIS_B_TILT] = wake_i && int_en[`AIS_B_TILT] &&
		motion_ctrl[`AIS_B_TF_EN] && tilt_det_i;
	assign set_vec[`AIS_B_FLIP] = wake_i && int_en[`AIS_B_FLIP] &&
		motion_ctrl[`AIS_B_TF_EN] && flip_det_i;
	assign set_vec[`AIS_B_GENERIC_MOVEMENT_DETECT] = wake_i && int_en[`AIS_B_GENERIC_MOVEMENT_DETECT] &&
		generic_movement_detect_on && generic_movement_detect_det_i;
	assign set_vec[`AIS_B_SHAKE] = wake_i && int_en[`AIS_B_SHAKE] &&
		generic_movement_detect_on && motion_ctrl[`AIS_B_SHAKE_EN] &&
		shake_det_i;
	// double tap only in latched mode
	assign set_vec[`AIS_B_DTAP] = wake_i && int_en[`AIS_B_DTAP] &&
		generic_movement_detect_on && mode_latched && dtap_det_i;
	assign set_vec[`AIS_B_FIFOC] = 1'b0;
	assign set_vec[6] = 1'b0;
	// the sample flag is always live in status; its enable gates the request
	assign set_vec[`AIS_B_ACQ] = wake_i && z_done_i;

	// fifo flags exist in latched mode only
	assign fifo_set_vec[0] = 1'b0;
	assign fifo_set_vec[`AIS_B_FULL] = wake_i && mode_latched && fifo_en &&
		fifo_ctrl[`AIS_B_FULL] &&
		(fifo_count_i >= `AIS_FIFO_DEPTH);
	assign fifo_set_vec[`AIS_B_THR] = wake_i && mode_latched && fifo_en &&
		fifo_ctrl[`AIS_B_THR] &&
		({2'b00, fifo_count_i} >= fifo_thr);
	assign fifo_set_vec[7:3] = 5'h00;

	// conditions ordered as tilt, flip, generic_movement_detect, shake
	assign cond_now = {shake_cond_i, generic_movement_detect_cond_i, flip_cond_i, tilt_cond_i};
	assign cond_end = cond_q & ~cond_now;

	// ----------------------------------------------------------------
	// next flag values
	// ----------------------------------------------------------------
	always @* begin
		next_isr      = isr;
		next_fifo_isr = fifo_isr;
		if (wake_i) begin
			// hardware clears per mode; latched mode has none
			if (mode_temp && tl_expire) begin
				next_isr[`AIS_B_ACQ]   = 1'b0;
				next_isr[`AIS_B_SHAKE] = 1'b0;
				next_isr[`AIS_B_GENERIC_MOVEMENT_DETECT]  = 1'b0;
				next_isr[`AIS_B_TILT]  = 1'b0;
				next_isr[`AIS_B_FLIP]  = 1'b0;
			end
			if (mode_auto) begin
				if (z_accum_start_i)
					next_isr[`AIS_B_ACQ] = 1'b0;
				if (motion_hw_clr_i)
					next_isr[3:0] = 4'h0;
				else
					next_isr[3:0] = next_isr[3:0] & ~cond_end;
			end
			// software clear; the status read also drops the sample flag
			next_isr = next_isr & ~{clr_mask[7:6], 1'b0, clr_mask[4:0]};
			if (rd_isr)
				next_isr[`AIS_B_ACQ] = 1'b0;
			if (clr_fifo)
				next_fifo_isr = 8'h00;
		end
		// sets are applied last so a coinciding clear loses
		next_isr      = next_isr | set_vec;
		next_fifo_isr = next_fifo_isr | fifo_set_vec;
	end

	// ----------------------------------------------------------------
	// flag, history and timer state
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			isr      <= `AIS_RST_ZERO;
			fifo_isr <= `AIS_RST_ZERO;
			cond_q   <= 4'h0;
		end else if (ce_i) begin
			isr      <= next_isr;
			fifo_isr <= next_fifo_isr;
			cond_q   <= cond_now;
		end
	end

	// timer restarts on every new flag; the period is in steps of
	// 2**TL_SHIFT clocks so a short field still reaches long times
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tl_cnt    <= {TLW{1'b0}};
			tl_run    <= 1'b0;
			tl_expire <= 1'b0;
		end else if (ce_i) begin
			tl_expire <= 1'b0;
			if (!mode_temp || !wake_i) begin
				tl_run <= 1'b0;
			end else if (|set_vec) begin
				tl_cnt <= {tl_period, {TL_SHIFT{1'b0}}};
				tl_run <= 1'b1;
			end else if (tl_run) begin
				if (tl_cnt == {TLW{1'b0}}) begin
					tl_run    <= 1'b0;
					tl_expire <= 1'b1;
				end else begin
					tl_cnt <= tl_cnt - {{(TLW-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// register writes and read data
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			int_en                 <= `AIS_RST_ZERO;
			motion_ctrl            <= `AIS_RST_ZERO;
			fifo_ctrl              <= `AIS_RST_ZERO;
			fifo_thr               <= `AIS_RST_FIFO_THR;
			svc_ctrl               <= `AIS_RST_ZERO;
			irq_pin_drive_polarity <= `AIS_RST_ZERO;
			tl_period              <= `AIS_RST_ZERO;
		end else if (ce_i && reg_wr_i) begin
			if (reg_addr_i == `AIS_ADDR_INT_EN)
				int_en <= reg_wdata_i;
			else if (reg_addr_i == `AIS_ADDR_MOTION_CTRL)
				motion_ctrl <= reg_wdata_i;
			else if (reg_addr_i == `AIS_ADDR_FIFO_CTRL)
				fifo_ctrl <= reg_wdata_i;
			else if (reg_addr_i == `AIS_ADDR_FIFO_THR)
				fifo_thr <= reg_wdata_i;
			else if (reg_addr_i == `AIS_ADDR_SVC_CTRL)
				svc_ctrl <= reg_wdata_i;
			else if (reg_addr_i == `AIS_ADDR_PIN_CTRL)
				irq_pin_drive_polarity <= reg_wdata_i & 8'hCC;
			else if (reg_addr_i == `AIS_ADDR_TL_PERIOD)
				tl_period <= reg_wdata_i;
		end
	end

	// reads answer in any state, one cycle after the strobe
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (ce_i && reg_rd_i) begin
			if ((reg_addr_i == `AIS_ADDR_ISR) ||
			    (reg_addr_i == `AIS_ADDR_ISR_ALT))
				reg_rdata_o <= isr;
			else if (reg_addr_i == `AIS_ADDR_INT_EN)
				reg_rdata_o <= int_en;
			else if (reg_addr_i == `AIS_ADDR_MOTION_CTRL)
				reg_rdata_o <= motion_ctrl;
			else if (reg_addr_i == `AIS_ADDR_FIFO_CTRL)
				reg_rdata_o <= fifo_ctrl;
			else if (reg_addr_i == `AIS_ADDR_FIFO_THR)
				reg_rdata_o <= fifo_thr;
			else if (reg_addr_i == `AIS_ADDR_FIFO_ISR)
				reg_rdata_o <= fifo_isr;
			else if (reg_addr_i == `AIS_ADDR_SVC_CTRL)
				reg_rdata_o <= svc_ctrl;
			else if (reg_addr_i == `AIS_ADDR_PIN_CTRL)
				reg_rdata_o <= irq_pin_drive_polarity;
			else if (reg_addr_i == `AIS_ADDR_TL_PERIOD)
				reg_rdata_o <= tl_period;
			else
				reg_rdata_o <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// requests and pin routing
	// ----------------------------------------------------------------
	wire req_motion;
	wire req_fifo;
	wire primary_irq_request;
	wire secondary_irq_request;
	wire pin_a_req;
	wire pin_b_req;

	// enables gate the request again so disabling one drops the pin
	assign req_motion = |(isr & int_en & 8'h9F);
	assign req_fifo   = |(fifo_isr & fifo_ctrl &
		((8'h01 << `AIS_B_FULL) | (8'h01 << `AIS_B_THR)));

	assign primary_irq_request = req_motion ||
		(request_merge_enable && req_fifo);
	assign secondary_irq_request = !request_merge_enable &&
		req_fifo;

	assign pin_a_req = request_pin_exchange ? secondary_irq_request
	                                        : primary_irq_request;
	assign pin_b_req = request_pin_exchange ? primary_irq_request
	                                        : secondary_irq_request;

	ais_pin_drv u_pin_a (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.ce_i      (ce_i),
		.req_i     (pin_a_req),
		.pol_i     (irq_pin_drive_polarity[`AIS_B_A_POL]),
		.drv_i     (irq_pin_drive_polarity[`AIS_B_A_DRV]),
		.pin_out_o (irq_pin_a_out_o),
		.pin_oe_o  (irq_pin_a_oe_o)
	);

	ais_pin_drv u_pin_b (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.ce_i      (ce_i),
		.req_i     (pin_b_req),
		.pol_i     (irq_pin_drive_polarity[`AIS_B_B_POL]),
		.drv_i     (irq_pin_drive_polarity[`AIS_B_B_DRV]),
		.pin_out_o (irq_pin_b_out_o),
		.pin_oe_o  (irq_pin_b_oe_o)
	);

endmodule // ais_top

`default_nettype wire

//--- sim/ais_top_checker.sv
// port-level assertions for the interrupt servicer
`timescale 1ns/1ps
`default_nettype none
module ais_top_checker #(
	parameter integer TL_SHIFT = 8
) (
	// clock, reset, register port
	input wire logic       clk_i,
	input wire logic       arst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// state and events
	input wire logic       wake_i,
	input wire logic       z_done_i,
	input wire logic       dtap_det_i,
	input wire logic       shake_det_i,
	input wire logic       generic_movement_detect_det_i,
	input wire logic       tilt_det_i,
	input wire logic       flip_det_i,
	// pins
	input wire logic       irq_pin_a_out_o,
	input wire logic       irq_pin_a_oe_o,
	input wire logic       irq_pin_b_out_o,
	input wire logic       irq_pin_b_oe_o
);
	// shadows of the routing registers; the bench keeps them stable
	// around events, which the pin checks rely on
	logic [7:0] pcfg, ien, svc, fctl;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pcfg <= 8'h00;
			ien  <= 8'h00;
			svc  <= 8'h00;
			fctl <= 8'h00;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				8'h33: pcfg <= reg_wdata_i;
				8'h06: ien <= reg_wdata_i;
				8'h31: svc <= reg_wdata_i;
				8'h2D: fctl <= reg_wdata_i;
				default: ;
			endcase
		end
	end
	// released pins float up to the rail
	wire a_act = ((irq_pin_a_oe_o ? irq_pin_a_out_o : 1'b1) == pcfg[2]);
	wire b_act = ((irq_pin_b_oe_o ? irq_pin_b_out_o : 1'b1) == pcfg[6]);
	wire ev    = z_done_i | dtap_det_i | shake_det_i | generic_movement_detect_det_i |
	             tilt_det_i | flip_det_i;
	wire plain = (svc[1:0] == 2'h0) && !fctl[3];
	wire acq   = z_done_i && wake_i && ien[7] && plain;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	a_od_a_low: assert property (
		!$past(pcfg[3]) |-> !irq_pin_a_out_o)
		else $error("pin a driven high in open drain");
	a_od_b_low: assert property (
		!$past(pcfg[7]) |-> !irq_pin_b_out_o)
		else $error("pin b driven high in open drain");
	a_pp_drives: assert property (
		(!$past(pcfg[3]) || irq_pin_a_oe_o) &&
		(!$past(pcfg[7]) || irq_pin_b_oe_o))
		else $error("push-pull pin not driven");
	a_ctrl_readback: assert property (
		reg_rd_i && reg_addr_i == 8'h33 |=>
		reg_rdata_o == ($past(pcfg) & 8'hCC))
		else $error("pin control read back wrong");
	a_sample_on_a: assert property (
		acq && !svc[4] |-> ##2 a_act)
		else $error("sample request missing on pin a");
	a_swap_to_b: assert property (
		acq && svc[4] |-> ##2 b_act)
		else $error("swapped sample request missing on pin b");
	a_global_clear: assert property (
		reg_wr_i && reg_addr_i == 8'h04 && wake_i && !svc[6] && plain &&
		!svc[4] && !ev && !$past(ev) |-> ##2 !a_act)
		else $error("global clear left pin a active");
	a_mask_keeps: assert property (
		reg_wr_i && reg_addr_i == 8'h04 && svc[6] && plain && !svc[4] &&
		a_act && !reg_rd_i |-> ##2 a_act)
		else $error("secondary address cleared in bitmask mode");
	a_merge_quiets_b: assert property (
		fctl[3] && !svc[4] |=> !b_act)
		else $error("pin b active while combined");
endmodule // ais_top_checker
`default_nettype wire

//--- sim/ais_host_model.sv
// host side of the interrupt pins: pull-ups and resolved levels
`timescale 1ns/1ps
`default_nettype none
module ais_host_model (
	// device pin drivers
	input  wire logic a_out_i,
	input  wire logic a_oe_i,
	input  wire logic b_out_i,
	input  wire logic b_oe_i,
	// wire levels seen by the host
	output wire logic lvl_a_o,
	output wire logic lvl_b_o
);
	// a released pin is pulled up, so open drain reads high when idle if active low, low when idle if active high
	assign lvl_a_o = a_oe_i ? a_out_i : 1'b1;
	assign lvl_b_o = b_oe_i ? b_out_i : 1'b1;
endmodule // ais_host_model
`default_nettype wire

//--- sim/test_ais_top.sv
// self-checking bench of the interrupt servicer
`timescale 1ns/1ps
`default_nettype none
module test_ais_top;
	logic        clk_i = 1'b0, arst_n_i = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        wake = 1'b0, prb = 1'b0, rd_d = 1'b0;
	logic [7:0]  addr = 8'h00, wd = 8'h00, rdata;
	logic [4:0]  det = 5'h00;
	logic [3:0]  cnd = 4'h0;
	logic [2:0]  sp = 3'h0;
	logic [5:0]  cnt = 6'h00;
	logic        a_out, a_oe, b_out, b_oe, lvl_a, lvl_b;
	logic [7:0]  rq[$];
	logic [1:0]  pq[$];
	logic [31:0] rs = 32'd32810;
	int          err_total = 0, tests_run = 0;

	ais_top #(.TL_SHIFT(2)) dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.ce_i(1'b1), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .wake_i(wake),
		.z_done_i(sp[0]), .z_accum_start_i(sp[1]), .motion_hw_clr_i(sp[2]),
		.tilt_det_i(det[0]), .flip_det_i(det[1]), .generic_movement_detect_det_i(det[2]),
		.shake_det_i(det[3]), .dtap_det_i(det[4]), .tilt_cond_i(cnd[0]),
		.flip_cond_i(cnd[1]), .generic_movement_detect_cond_i(cnd[2]), .shake_cond_i(cnd[3]),
		.fifo_count_i(cnt), .irq_pin_a_out_o(a_out), .irq_pin_a_oe_o(a_oe),
		.irq_pin_b_out_o(b_out), .irq_pin_b_oe_o(b_oe));
	ais_host_model host_u (.a_out_i(a_out), .a_oe_i(a_oe), .b_out_i(b_out),
		.b_oe_i(b_oe), .lvl_a_o(lvl_a), .lvl_b_o(lvl_b));

	initial forever #2 clk_i = ~clk_i;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// an idle edge after each access, so back-to-back calls never
	// drop and raise a strobe in one time step
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wd = d;
		wr = 1'b1;
		tick();
		wr = 1'b0;
		tick();
	endtask
	task automatic rdr(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		addr = a;
		rd = 1'b1;
		tick();
		rd = 1'b0;
		tick();
	endtask
	// pins lag a flag by a flop, so let two edges pass before probing
	task automatic pins(input logic ea, input logic eb);
		tick(2);
		pq.push_back({ea, eb});
		prb = 1'b1;
		tick();
		prb = 1'b0;
	endtask
	task automatic ev(input logic [4:0] d, input logic [2:0] s);
		det = d;
		sp = s;
		tick();
		det = 5'h00;
		sp = 3'h0;
		tick();
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk_i) begin
		if (rd_d)
			chk(rdata, rq.pop_front());
		if (prb)
			chk({6'h00, lvl_a, lvl_b}, {6'h00, pq.pop_front()});
		rd_d <= rd;
	end

	initial begin
		#20000;
		err_total++;
		test_done();
	end

	initial begin
		tick(16);
		arst_n_i = 1'b1;
		wake = 1'b1;
		rdr(8'h33, 8'h00);
		rdr(8'h2E, 8'h10);
		rdr(8'h50, 8'h00);
		repeat (4) begin
			rs = xs(rs);
			wrr(8'h33, rs[7:0]);
			rdr(8'h33, rs[7:0] & 8'hCC);
		end
		wrr(8'h33, 8'h00);
		wrr(8'h09, 8'h08);
		wrr(8'h06, 8'h9F);
		ev(5'h18, 3'h1);
		pins(1'b0, 1'b1);
		rdr(8'h14, 8'h80);
		pins(1'b1, 1'b1);
		wrr(8'h09, 8'h0D);
		for (int i = 0; i < 5; i++) begin
			ev(5'h01 << i, 3'h0);
			rdr(8'h14, 8'h01 << i);
			rs = xs(rs);
			wrr(rs[0] ? 8'h04 : 8'h14, rs[15:8]);
			rdr(8'h14, 8'h00);
		end
		// clear and set land on the same edge
		addr = 8'h14;
		wr = 1'b1;
		det = 5'h01;
		tick();
		wr = 1'b0;
		det = 5'h00;
		tick();
		rdr(8'h14, 8'h01);
		cnd = 4'h3;
		ev(5'h02, 3'h0);
		cnd = 4'h0;
		ev(5'h00, 3'h4);
		tick(20);
		rdr(8'h14, 8'h03);
		wrr(8'h14, 8'h00);
		wrr(8'h31, 8'h40);
		ev(5'h1F, 3'h0);
		wrr(8'h04, 8'hFF);
		rdr(8'h14, 8'h1F);
		wrr(8'h14, 8'h05);
		rdr(8'h14, 8'h1A);
		wrr(8'h14, 8'h1A);
		wrr(8'h2E, 8'h04);
		wrr(8'h2D, 8'h26);
		cnt = 6'd3;
		tick(2);
		rdr(8'h2F, 8'h00);
		cnt = 6'd4;
		tick(2);
		rdr(8'h2F, 8'h04);
		cnt = 6'd32;
		tick(2);
		cnt = 6'd0;
		pins(1'b1, 1'b0);
		rdr(8'h2F, 8'h06);
		wrr(8'h14, 8'h1F);
		rdr(8'h2F, 8'h06);
		wrr(8'h14, 8'h20);
		rdr(8'h2F, 8'h00);
		wrr(8'h31, 8'h00);
		cnt = 6'd32;
		tick(2);
		cnt = 6'd0;
		wrr(8'h2D, 8'h2E);
		pins(1'b0, 1'b1);
		wrr(8'h31, 8'h10);
		pins(1'b1, 1'b0);
		wrr(8'h31, 8'h00);
		wrr(8'h2D, 8'h26);
		wrr(8'h04, 8'h00);
		rdr(8'h2F, 8'h00);
		ev(5'h00, 3'h1);
		for (int i = 0; i < 16; i++) begin
			wrr(8'h33, {i[3:2], 2'h0, i[1:0], 2'h0});
			pins(i[0], !i[2]);
		end
		wrr(8'h31, 8'h10);
		ev(5'h00, 3'h1);
		pins(1'b0, 1'b1);
		wrr(8'h31, 8'h00);
		wrr(8'h33, 8'h00);
		rdr(8'h14, 8'h80);
		wrr(8'h4A, 8'h01);
		wrr(8'h31, 8'h01);
		ev(5'h11, 3'h0);
		rdr(8'h14, 8'h01);
		tick(12);
		rdr(8'h14, 8'h00);
		wrr(8'h31, 8'h02);
		cnd = 4'hF;
		ev(5'h0F, 3'h0);
		cnd = 4'hE;
		tick(2);
		rdr(8'h14, 8'h0E);
		ev(5'h00, 3'h4);
		rdr(8'h14, 8'h00);
		cnd = 4'h0;
		ev(5'h00, 3'h1);
		pins(1'b0, 1'b1);
		ev(5'h00, 3'h2);
		pins(1'b1, 1'b1);
		wrr(8'h31, 8'h00);
		ev(5'h01, 3'h0);
		wake = 1'b0;
		ev(5'h02, 3'h0);
		wrr(8'h04, 8'h00);
		rdr(8'h14, 8'h01);
		wake = 1'b1;
		wrr(8'h14, 8'h00);
		rdr(8'h14, 8'h00);
		tick(4);
		test_done();
	end
endmodule // test_ais_top

bind ais_top ais_top_checker #(.TL_SHIFT(TL_SHIFT)) chk_u (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .wake_i(wake_i), .z_done_i(z_done_i),
	.dtap_det_i(dtap_det_i), .shake_det_i(shake_det_i),
	.generic_movement_detect_det_i(generic_movement_detect_det_i), .tilt_det_i(tilt_det_i),
	.flip_det_i(flip_det_i), .irq_pin_a_out_o(irq_pin_a_out_o),
	.irq_pin_a_oe_o(irq_pin_a_oe_o), .irq_pin_b_out_o(irq_pin_b_out_o),
	.irq_pin_b_oe_o(irq_pin_b_oe_o));
`default_nettype wire
